// ### design/stl_checker.sv
// module: software travel limit checker with avalon-mm register slave
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module stl_checker (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire stl_pkg::stl_pos_t        pos_in,
  input  wire logic                     hw_limit_hit,
  input  wire stl_pkg::stl_avm_req_t    avm_req,
  output logic [stl_pkg::DATA_W-1:0]    avm_readdata,
  output logic                          avm_waitrequest,
  output stl_pkg::stl_flags_t           flags_out,
  output logic                          limit_stop_request,
  output logic                          irq
);
  import stl_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic              soft_limit_enable;
  logic [POS_W-1:0]  lower_soft_limit_position;
  logic [POS_W-1:0]  upper_soft_limit_position;
  logic [1:0]        irq_mask;
  logic [1:0]        evt_sticky;
  logic              ack_done;

  // ---------------------------------------------------------------
  // comparisons
  // ---------------------------------------------------------------
  wire logic armed = soft_limit_enable & pos_in.abs_valid;
  wire logic at_lower = $signed(pos_in.position)
                        <= $signed(lower_soft_limit_position);
  wire logic at_upper = $signed(pos_in.position)
                        >= $signed(upper_soft_limit_position);
  // lower and upper flags drop when strictly inside or disarmed
  wire logic next_lower = armed & at_lower;
  wire logic next_upper = armed & at_upper;
  wire logic next_stop  = next_lower | next_upper | hw_limit_hit;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire logic access   = (avm_req.read | avm_req.write) & ~ack_done;
  wire logic wr_ctrl  = access & avm_req.write
                        & (avm_req.address == OFF_CTRL);
  wire logic wr_lower = access & avm_req.write
                        & (avm_req.address == OFF_LOWER);
  wire logic wr_upper = access & avm_req.write
                        & (avm_req.address == OFF_UPPER);
  wire logic rd_stat  = access & avm_req.read
                        & (avm_req.address == OFF_STATUS);
  wire logic [1:0] new_evt = {next_upper & ~flags_out.upper_soft_limit_flag,
                              next_lower & ~flags_out.lower_soft_limit_flag};
  // set wins over the read clear
  wire logic [1:0] next_evt = (rd_stat ? 2'h0 : evt_sticky) | new_evt;
  wire logic [DATA_W-1:0] ctrl_word =
    DATA_W'({irq_mask, 7'h00, soft_limit_enable});
  wire logic [DATA_W-1:0] stat_word =
    DATA_W'({evt_sticky, 5'h00, flags_out.limit_stop,
             flags_out.upper_soft_limit_flag,
             flags_out.lower_soft_limit_flag});
  wire logic [DATA_W-1:0] next_rdata =
    (avm_req.address == OFF_CTRL)   ? ctrl_word :
    (avm_req.address == OFF_LOWER)  ? lower_soft_limit_position :
    (avm_req.address == OFF_UPPER)  ? upper_soft_limit_position :
    (avm_req.address == OFF_STATUS) ? stat_word : UNMAPPED_DATA;

  // ---------------------------------------------------------------
  // limit outputs
  // ---------------------------------------------------------------
  // flags and stop request registered each cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_out          <= '0;
      limit_stop_request <= 1'b0;
    end else begin
      flags_out          <= '{next_lower, next_upper, next_stop};
      limit_stop_request <= next_stop;
    end
  end

  // ---------------------------------------------------------------
  // bus slave: one wait cycle then acknowledge
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_done        <= 1'b0;
      avm_waitrequest <= 1'b1;
      avm_readdata    <= '0;
    end else begin
      ack_done        <= access;
      avm_waitrequest <= ~access;
      if (access && avm_req.read) begin
        avm_readdata <= next_rdata;
      end
    end
  end

  // software settings
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      soft_limit_enable         <= 1'b0;
      irq_mask                  <= MASK_RST;
      lower_soft_limit_position <= LOWER_RST;
      upper_soft_limit_position <= UPPER_RST;
    end else begin
      if (wr_ctrl) begin
        soft_limit_enable <= avm_req.writedata[CTRL_EN_BIT];
        irq_mask <= avm_req.writedata[CTRL_MASK_HI:CTRL_MASK_LO];
      end
      if (wr_lower) begin
        lower_soft_limit_position <= avm_req.writedata;
      end
      if (wr_upper) begin
        upper_soft_limit_position <= avm_req.writedata;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evt_sticky <= 2'h0;
      irq        <= 1'b0;
    end else begin
      evt_sticky <= next_evt;
      irq        <= |(next_evt & irq_mask);
    end
  end

endmodule

// ### design/stl_pkg.sv
// package: register map, field layout and shared types of the travel limit checker
package stl_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned POS_W  = 32;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_LOWER  = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_UPPER  = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'hc;

  // control fields
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_MASK_LO   = 8;
  localparam int unsigned CTRL_MASK_HI   = 9;

  // status fields: live flags, then sticky events
  localparam int unsigned ST_LOWER_BIT   = 0;
  localparam int unsigned ST_UPPER_BIT   = 1;
  localparam int unsigned ST_STOP_BIT    = 2;
  localparam int unsigned ST_EVT_LO      = 8;
  localparam int unsigned ST_EVT_HI      = 9;

  // reset values and unmapped read data
  localparam logic [POS_W-1:0] LOWER_RST = 32'h8000_0000;
  localparam logic [POS_W-1:0] UPPER_RST = 32'h7fff_ffff;
  localparam logic [1:0]       MASK_RST  = 2'h0;
  localparam logic [DATA_W-1:0] UNMAPPED_DATA = 32'h0000_0000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [POS_W-1:0] position;  // signed commanded axis position
    logic             abs_valid; // absolute position reference valid
  } stl_pos_t;

  typedef struct packed {
    logic lower_soft_limit_flag;
    logic upper_soft_limit_flag;
    logic limit_stop;            // halt with limit stop decel ramp
  } stl_flags_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
  } stl_avm_req_t;

endpackage

// ### sim/stl_sva_checker.sv
// port assertions for the travel limit checker
`timescale 1ns/100ps
module stl_sva (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire stl_pkg::stl_pos_t     pos_in,
  input wire logic                  hw_limit_hit,
  input wire stl_pkg::stl_avm_req_t avm_req,
  input wire logic [31:0]           avm_readdata,
  input wire logic                  avm_waitrequest,
  input wire stl_pkg::stl_flags_t   flags_out,
  input wire logic                  limit_stop_request,
  input wire logic                  irq
);
  import stl_pkg::*;
  // short names for the watched levels
  wire lo = flags_out.lower_soft_limit_flag;
  wire up = flags_out.upper_soft_limit_flag;
  wire rq = avm_req.read | avm_req.write;
  wire wt = avm_waitrequest;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_STOP_SRC: assert property (
    $past(!rst) |-> limit_stop_request == (lo | up | $past(hw_limit_hit)))
    else $error("stop request cause");
  AST_LO_GATE: assert property (
    !pos_in.abs_valid |=> !lo) else $error("lower flag gate");
  AST_UP_GATE: assert property (
    !pos_in.abs_valid |=> !up) else $error("upper flag gate");
  AST_ACK_ONE: assert property (
    rq && wt |=> !wt) else $error("ack late");
  AST_ACK_PULSE: assert property (!wt |=> wt) else $error("ack long");
  AST_ACK_CAUSE: assert property (!wt |-> $past(rq)) else $error("stray ack");
  AST_RD_HOLD: assert property (
    $changed(avm_readdata) |-> !wt) else $error("read data moved");
  AST_IRQ_FALL: assert property (
    $fell(irq) |-> $past(rq)) else $error("irq dropped");
  C_LO: cover property (lo);
  C_UP: cover property (up);
  C_IRQ: cover property (irq);
endmodule
bind stl_checker stl_sva chk_u (.sys_clk, .rst, .pos_in, .hw_limit_hit,
  .avm_req, .avm_readdata, .avm_waitrequest, .flags_out,
  .limit_stop_request, .irq);

// ### sim/stl_traj_model.sv
// trajectory and feedback stand-in feeding position and limit switch
`timescale 1ns/100ps
module stl_traj_model (
  input  wire logic        sys_clk,
  input  wire logic [31:0] cmd_pos,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_hw,
  output stl_pkg::stl_pos_t pos_in,
  output logic             hw_limit_hit
);
  import stl_pkg::*;
  // one motion tick of delay, like a real feedback register
  initial {pos_in, hw_limit_hit} = '0;
  always @(posedge sys_clk) begin
    pos_in <= '{cmd_pos, cmd_valid};
    hw_limit_hit <= cmd_hw;
  end
endmodule

// ### sim/stl_checker_tb.sv
// self-checking bench for the travel limit checker
`timescale 1ns/100ps
module stl_checker_tb;
  import stl_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic         sys_clk = 0, rst = 1, v = 0, h = 0;
  logic [31:0]  p = 0, rd, avm_readdata;
  int           failures = 0, compares = 0;
  stl_avm_req_t avm_req = '0;
  stl_pos_t     pos_in;
  stl_flags_t   flags_out;
  logic         avm_waitrequest, hw_limit_hit, limit_stop_request, irq;
  wire [2:0]    luq = {flags_out.lower_soft_limit_flag,
                       flags_out.upper_soft_limit_flag, limit_stop_request};
  always #50 sys_clk = ~sys_clk;
  stl_traj_model traj_u (.sys_clk, .cmd_pos(p), .cmd_valid(v), .cmd_hw(h),
    .pos_in, .hw_limit_hit);
  stl_checker dut_u (.sys_clk, .rst, .pos_in, .hw_limit_hit, .avm_req,
    .avm_readdata, .avm_waitrequest, .flags_out, .limit_stop_request, .irq);
  task automatic chk(input string what, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  // bus cycle held until waitrequest is seen low
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    avm_req <= '{a, !w, w, d};
    // waitrequest and read data are taken at the rising edge itself
    do begin
      @(posedge sys_clk);
      n++;
    end while (avm_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) failures++;
    rd = avm_readdata;
    avm_req <= '0;
  endtask
  task automatic drive(input logic [31:0] np, input logic nv, nh);
    @(posedge sys_clk);
    p <= np;
    v <= nv;
    h <= nh;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic t_regs;
    bus(OFF_CTRL, 0, 0); chk("ctrl", 0, rd);
    bus(OFF_LOWER, 0, 0); chk("lower", LOWER_RST, rd);
    bus(OFF_UPPER, 0, 0); chk("upper", UPPER_RST, rd);
    bus(4'h2, 0, 0); chk("unmapped", UNMAPPED_DATA, rd);
    $display("test regs done");
  endtask
  task automatic t_window;
    logic [31:0] tp [6] = '{32'hffff_ff9b, 32'hffff_ff9c, 32'hffff_ff9d,
                            32'h63, 32'h64, 32'h65};
    logic [2:0] te [6] = '{3'h5, 3'h5, 3'h0, 3'h0, 3'h3, 3'h3};
    bus(OFF_LOWER, 1, 32'hffff_ff9c);
    bus(OFF_UPPER, 1, 32'h64);
    bus(OFF_CTRL, 1, 32'h101);
    foreach (tp[i]) begin
      drive(tp[i], 1, 0);
      chk("window", {29'h0, te[i]}, {29'h0, luq});
    end
    drive(32'hffff_ff00, 0, 0); chk("novalid", 0, {29'h0, luq});
    drive(32'hffff_ff00, 1, 1); chk("valid", 5, {29'h0, luq});
    bus(OFF_CTRL, 1, 0);
    drive(32'hffff_ff00, 1, 1); chk("disabled", 1, {29'h0, luq});
    $display("test window done");
  endtask
  task automatic t_irq;
    drive(0, 1, 0);
    bus(OFF_CTRL, 1, 32'h101);
    bus(OFF_STATUS, 0, 0); chk("sticky", 32'h300, rd);
    repeat (2) @(negedge sys_clk);
    chk("irq clear", 0, {31'h0, irq});
    drive(32'hffff_ff6a, 1, 0); chk("irq set", 1, {31'h0, irq});
    bus(OFF_STATUS, 0, 0); chk("st lower", 32'h105, rd);
    drive(32'h96, 1, 0); chk("irq masked", 0, {31'h0, irq});
    bus(OFF_STATUS, 0, 0); chk("st upper", 32'h206, rd);
    $display("test irq done");
  endtask
  task automatic print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100_000;
    failures++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 0;
    t_regs;
    t_window;
    t_irq;
    print_verdict;
  end
endmodule
